//--- verilog/jtb_map.vh
`ifndef JTB_MAP_VH
`define JTB_MAP_VH

// Instruction register width and opcodes
`define JTB_IR_WIDTH 4
`define JTB_OP_BYPASS 4'hf
`define JTB_OP_EXTEST 4'h0
`define JTB_OP_SAMPLE 4'h4
`define JTB_OP_IDCODE 4'hd
`define JTB_OP_SCAN 4'h7
`define JTB_OP_HIGHZ 4'h5

// Capture pattern loaded in capture-IR, low two bits fixed at 01
`define JTB_IR_CAPTURE 4'h1

// Instruction selected after test reset
`define JTB_IR_RESET `JTB_OP_IDCODE

// Identification register width and its fixed low bit position
`define JTB_ID_WIDTH 32
`define JTB_ID_LSB 0

// Least run of TMS-high clocks that a tester uses to reset the port
`define JTB_TMS_RESET_CYCLES 10

// Level an undriven TMS or TDI reads as
`define JTB_PIN_IDLE 1'b1

`endif

//--- verilog/jtb_tap.v
`timescale 1ns/1ps
`include "jtb_map.vh"

module jtb_tap #(
    parameter NUM_IN = 4,
    parameter NUM_OUT = 4,
    parameter NUM_IO = 4,
    // Identification value, arbitrary, low bit must stay 1
    parameter [31:0] ID_CODE = 32'h00000001
) (
    // System clock and reset
    input wire clk_sys,
    input wire rst_b,
    // Test port pins
    input wire tck,
    input wire tms,
    input wire tdi,
    input wire testRst_b,
    output reg tdo,
    output reg tdoOe_b,
    // Input-only pins
    input wire [NUM_IN-1:0] padIn,
    output reg [NUM_IN-1:0] coreIn,
    // Output-only pins
    input wire [NUM_OUT-1:0] coreOut,
    output reg [NUM_OUT-1:0] padOut,
    output reg [NUM_OUT-1:0] padOutOe_b,
    // Bidirectional pins
    input wire [NUM_IO-1:0] coreIoOut,
    input wire [NUM_IO-1:0] coreIoOe_b,
    output reg [NUM_IO-1:0] coreIoIn,
    input wire [NUM_IO-1:0] padIoIn,
    output reg [NUM_IO-1:0] padIoOut,
    output reg [NUM_IO-1:0] padIoOe_b,
    // Internal scan chain
    output reg scanEnable,
    output reg scanStep,
    output reg scanData,
    input wire scanReturn
);

    localparam CHAIN = NUM_IN + NUM_OUT + 2 * NUM_IO;
    localparam OFS_OUT = NUM_IN;
    localparam OFS_IOD = NUM_IN + NUM_OUT;
    localparam OFS_IOE = NUM_IN + NUM_OUT + NUM_IO;

    localparam [3:0] ST_RESET = 4'h0;
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_SEL_DR = 4'h2;
    localparam [3:0] ST_CAP_DR = 4'h3;
    localparam [3:0] ST_SH_DR = 4'h4;
    localparam [3:0] ST_EX1_DR = 4'h5;
    localparam [3:0] ST_PAU_DR = 4'h6;
    localparam [3:0] ST_EX2_DR = 4'h7;
    localparam [3:0] ST_UPD_DR = 4'h8;
    localparam [3:0] ST_SEL_IR = 4'h9;
    localparam [3:0] ST_CAP_IR = 4'ha;
    localparam [3:0] ST_SH_IR = 4'hb;
    localparam [3:0] ST_EX1_IR = 4'hc;
    localparam [3:0] ST_PAU_IR = 4'hd;
    localparam [3:0] ST_EX2_IR = 4'he;
    localparam [3:0] ST_UPD_IR = 4'hf;

    // Pin synchronisers, first stage read only by the second
    reg tckS1, tckS2, tckPrev;
    reg tmsS1, tmsS2, tdiS1, tdiS2;
    reg [NUM_IN-1:0] padInS1, padInS2;
    reg [NUM_IO-1:0] padIoS1, padIoS2;

    reg [3:0] state;
    reg [3:0] next_state;
    reg [`JTB_IR_WIDTH-1:0] irShift;
    reg [`JTB_IR_WIDTH-1:0] ir;
    reg bypassBit;
    reg [`JTB_ID_WIDTH-1:0] idShift;
    reg [CHAIN-1:0] cellShift;
    reg [CHAIN-1:0] cellUpd;

    wire tckRise = tckS2 & ~tckPrev;
    wire tckFall = ~tckS2 & tckPrev;
    wire [CHAIN-1:0] cellCapture;

    // Undriven pins idle high, so the tms and tdi synchronisers start at that level
    // idle high default
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tckS1 <= 1'b0;
            tckS2 <= 1'b0;
            tckPrev <= 1'b0;
            tmsS1 <= `JTB_PIN_IDLE;
            tmsS2 <= `JTB_PIN_IDLE;
            tdiS1 <= `JTB_PIN_IDLE;
            tdiS2 <= `JTB_PIN_IDLE;
            padInS1 <= {NUM_IN{1'b0}};
            padInS2 <= {NUM_IN{1'b0}};
            padIoS1 <= {NUM_IO{1'b0}};
            padIoS2 <= {NUM_IO{1'b0}};
        end
        else
        begin
            tckS1 <= tck;
            tckS2 <= tckS1;
            tckPrev <= tckS2;
            tmsS1 <= tms;
            tmsS2 <= tmsS1;
            tdiS1 <= tdi;
            tdiS2 <= tdiS1;
            padInS1 <= padIn;
            padInS2 <= padInS1;
            padIoS1 <= padIoIn;
            padIoS2 <= padIoS1;
        end
    end

    // Instruction decode
    // bypass extest sample
    wire opExtest = (ir == `JTB_OP_EXTEST);
    wire opSample = (ir == `JTB_OP_SAMPLE);
    wire opIdcode = (ir == `JTB_OP_IDCODE);
    wire opScan = (ir == `JTB_OP_SCAN);
    wire opHighz = (ir == `JTB_OP_HIGHZ);
    wire selCells = opExtest | opSample;

    // Capture sources: inputs and io data from pins, outputs from core
    // input cell sample
    assign cellCapture = {coreIoOe_b, padIoS2, coreOut, padInS2};

    // Sixteen-state controller transition table
    // sixteen state table
    always @*
    begin
        next_state = state;
        case (state)
            ST_RESET: next_state = tmsS2 ? ST_RESET : ST_IDLE;
            ST_IDLE: next_state = tmsS2 ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: next_state = tmsS2 ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: next_state = tmsS2 ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: next_state = tmsS2 ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: next_state = tmsS2 ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: next_state = tmsS2 ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: next_state = tmsS2 ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: next_state = tmsS2 ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: next_state = tmsS2 ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: next_state = tmsS2 ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: next_state = tmsS2 ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: next_state = tmsS2 ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: next_state = tmsS2 ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: next_state = tmsS2 ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: next_state = tmsS2 ? ST_SEL_DR : ST_IDLE;
            default: next_state = ST_RESET;
        endcase
    end

    // Controller and test registers; test reset acts at once
    always @(posedge clk_sys or negedge rst_b or negedge testRst_b)
    begin
        if (!rst_b || !testRst_b)
        begin
            state <= ST_RESET;
            ir <= `JTB_IR_RESET;
            irShift <= `JTB_IR_CAPTURE;
            bypassBit <= 1'b0;
            idShift <= {`JTB_ID_WIDTH{1'b0}};
            cellShift <= {CHAIN{1'b0}};
            cellUpd <= {CHAIN{1'b0}};
            scanEnable <= 1'b0;
            scanStep <= 1'b0;
            scanData <= 1'b0;
        end
        else
        begin
            scanStep <= 1'b0;
            scanEnable <= opScan & (state == ST_SH_DR); // Spans every step, even the last
            if (tckRise)
            begin
                state <= next_state;
                case (state)
                    ST_RESET:
                    begin
                        ir <= `JTB_IR_RESET;
                    end
                    ST_CAP_IR:
                    begin
                        irShift <= `JTB_IR_CAPTURE;
                    end
                    ST_SH_IR:
                    begin
                        irShift <= {tdiS2, irShift[`JTB_IR_WIDTH-1:1]};
                    end
                    ST_UPD_IR:
                    begin
                        ir <= irShift;
                    end
                    ST_CAP_DR:
                    begin
                        bypassBit <= 1'b0;
                        idShift <= ID_CODE;
                        if (selCells)
                        begin
                            cellShift <= cellCapture;
                        end
                    end
                    ST_SH_DR:
                    begin
                        bypassBit <= tdiS2;
                        idShift <= {tdiS2, idShift[`JTB_ID_WIDTH-1:1]};
                        if (selCells)
                        begin
                            cellShift <= {tdiS2, cellShift[CHAIN-1:1]};
                        end
                        if (opScan)
                        begin
                            scanData <= tdiS2;
                            scanStep <= 1'b1;
                        end
                    end
                    ST_UPD_DR:
                    begin
                        if (selCells)
                        begin
                            cellUpd <= cellShift;
                        end
                    end
                    default:
                    begin
                        irShift <= irShift;
                    end
                endcase
            end
        end
    end

    // Serial output changes on the falling edge, floats outside shifts
    always @(posedge clk_sys or negedge rst_b or negedge testRst_b)
    begin
        if (!rst_b || !testRst_b)
        begin
            tdo <= 1'b0;
            tdoOe_b <= 1'b1;
        end
        else if (tckFall)
        begin
            if (state == ST_SH_IR)
            begin
                tdo <= irShift[0];
                tdoOe_b <= 1'b0;
            end
            else if (state == ST_SH_DR)
            begin
                tdo <= selCells ? cellShift[0] : opIdcode ? idShift[0] :
                    opScan ? scanReturn : bypassBit;
                tdoOe_b <= 1'b0;
            end
            else
            begin
                tdoOe_b <= 1'b1;
            end
        end
    end

    // Pin drivers: functional path unless extest or highz is in force
    genvar gi;
    generate
        for (gi = 0; gi < NUM_IO; gi = gi + 1)
        begin : gIo
            always @(posedge clk_sys or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    padIoOut[gi] <= 1'b0;
                    padIoOe_b[gi] <= 1'b1;
                    coreIoIn[gi] <= 1'b0;
                end
                else
                begin
                    coreIoIn[gi] <= padIoS2[gi];
                    padIoOut[gi] <= opExtest ? cellUpd[OFS_IOD+gi] : coreIoOut[gi];
                    padIoOe_b[gi] <= opHighz | (opExtest ? cellUpd[OFS_IOE+gi] :
                        coreIoOe_b[gi]);
                end
            end
        end
    endgenerate

    // Output-only and input-only pins
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            padOut <= {NUM_OUT{1'b0}};
            padOutOe_b <= {NUM_OUT{1'b1}};
            coreIn <= {NUM_IN{1'b0}};
        end
        else
        begin
            coreIn <= padInS2;
            padOut <= opExtest ? cellUpd[OFS_IOD-1:OFS_OUT] : coreOut;
            padOutOe_b <= {NUM_OUT{opHighz}};
        end
    end

endmodule

//--- bench/jtb_tester.sv
`timescale 1ns/1ps
// Tester at the far end; tck stands still between frames
module jtb_tester (
    // Link pins
    output reg tck,
    output reg tms,
    output reg tdi,
    input wire tdo,
    input wire tdoOe_b
);
    reg [63:0] got;
    // Idle tms and tdi rest at the pull-up level, tck rests low
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        got = 64'h0;
    end
    // steers the state
    // One tck cycle: set up while low, read tdo just before the rise
    // Low 65 ns, high 60 ns keeps every change at the same clock offset
    task step(input m, input d);
    begin
        tms = m;
        tdi = d;
        #65;
        got = {(tdoOe_b ? 1'bz : tdo), got[63:1]};
        tck = 1'b1;
        #60;
        tck = 1'b0;
    end
    endtask
endmodule

//--- bench/jtb_tap_properties.sv
`timescale 1ns/1ps
// Port-level checks of the test port
module jtb_tap_properties #(
    parameter NUM_IN = 4,
    parameter NUM_OUT = 4,
    parameter NUM_IO = 4
) (
    // Watched ports
    input logic clk_sys,
    input logic rst_b,
    input logic tck,
    input logic testRst_b,
    input logic tdo,
    input logic tdoOe_b,
    input logic [NUM_IN-1:0] padIn,
    input logic [NUM_IN-1:0] coreIn,
    input logic [NUM_OUT-1:0] coreOut,
    input logic [NUM_OUT-1:0] padOut,
    input logic [NUM_OUT-1:0] padOutOe_b,
    input logic [NUM_IO-1:0] coreIoOut,
    input logic [NUM_IO-1:0] coreIoOe_b,
    input logic [NUM_IO-1:0] padIoOut,
    input logic [NUM_IO-1:0] padIoOe_b,
    input logic scanEnable,
    input logic scanStep
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    a_tdo_float_reset: assert property (!testRst_b |-> tdoOe_b)
        else $error("tdo enabled in test reset");
    a_pins_normal: assert property (!testRst_b ##1 !testRst_b |->
        padOut == $past(coreOut) && padOutOe_b == '0) else $error("pins not functional");
    a_io_normal: assert property (!testRst_b ##1 !testRst_b |->
        padIoOut == $past(coreIoOut) && padIoOe_b == $past(coreIoOe_b))
        else $error("io pins not functional");
    a_core_in_lag: assert property (rst_b && $past(rst_b) && $past(rst_b, 2) &&
        $past(rst_b, 3) |-> coreIn == $past(padIn, 3)) else $error("coreIn lag wrong");
    a_tdo_on_fall: assert property (testRst_b && $past(testRst_b) &&
        ($changed(tdo) || $changed(tdoOe_b)) |-> !$past(tck, 2))
        else $error("tdo moved off a tck fall");
    a_highz_all: assert property (|padOutOe_b |-> &padOutOe_b && &padIoOe_b)
        else $error("partial float");
    a_step_enabled: assert property (scanStep |-> scanEnable)
        else $error("scan step without enable");
    a_step_pulse: assert property (scanStep |=> !scanStep)
        else $error("scan step too long");
    cover property (scanStep);
    cover property (&padOutOe_b && testRst_b);
    cover property ($fell(tdoOe_b));
endmodule

bind jtb_tap jtb_tap_properties #(.NUM_IN(NUM_IN), .NUM_OUT(NUM_OUT), .NUM_IO(NUM_IO))
    i_props (.clk_sys(clk_sys), .rst_b(rst_b), .tck(tck), .testRst_b(testRst_b),
    .tdo(tdo), .tdoOe_b(tdoOe_b), .padIn(padIn), .coreIn(coreIn), .coreOut(coreOut),
    .padOut(padOut), .padOutOe_b(padOutOe_b), .coreIoOut(coreIoOut),
    .coreIoOe_b(coreIoOe_b), .padIoOut(padIoOut), .padIoOe_b(padIoOe_b),
    .scanEnable(scanEnable), .scanStep(scanStep));

//--- bench/jtb_tap_tb.sv
`timescale 1ns/1ps
`include "jtb_map.vh"
module jtb_tap_tb;
    localparam [31:0] ID = 32'h5a3c96e1; // Arbitrary value, low bit set
    reg clk_sys, rst_b, testRst_b, scanReturn;
    reg [1:0] padIn, coreOut, coreIoOut, coreIoOe_b, extIo;
    wire tck, tms, tdi, tdo, tdoOe_b, scanEnable, scanStep, scanData;
    wire [1:0] coreIn, padOut, padOutOe_b, coreIoIn, padIoOut, padIoOe_b, padIoIn;
    reg [31:0] r;
    reg [3:0] cap;
    reg [5:0] scanWord;
    integer failures, total_checks, steps;
    // Two-way pin level from both drivers
    assign padIoIn = (padIoOut & ~padIoOe_b) | (extIo & padIoOe_b);
    jtb_tap #(.NUM_IN(2), .NUM_OUT(2), .NUM_IO(2), .ID_CODE(ID)) i_dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi),
        .testRst_b(testRst_b), .tdo(tdo), .tdoOe_b(tdoOe_b), .padIn(padIn),
        .coreIn(coreIn), .coreOut(coreOut), .padOut(padOut), .padOutOe_b(padOutOe_b),
        .coreIoOut(coreIoOut), .coreIoOe_b(coreIoOe_b), .coreIoIn(coreIoIn),
        .padIoIn(padIoIn), .padIoOut(padIoOut), .padIoOe_b(padIoOe_b),
        .scanEnable(scanEnable), .scanStep(scanStep), .scanData(scanData),
        .scanReturn(scanReturn));
    jtb_tester i_tst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe_b(tdoOe_b));
    // Clock and scan pulse count
    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
        if (scanStep === 1'b1)
        begin
            steps <= steps + 1;
            scanWord <= {scanData, scanWord[5:1]};
        end
    task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
        total_checks = total_checks + 1;
        if (g !== e)
        begin
            failures = failures + 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    end
    endtask
    task clks(input integer n);
    begin
        repeat (n) @(posedge clk_sys);
        #1;
    end
    endtask
    // Data scan from Idle back to Idle, result LSB first in r
    task dr(input [31:0] v, input integer n);
        integer i;
    begin
        i_tst.step(1, 1);
        i_tst.step(0, 1);
        i_tst.step(0, 1);
        for (i = 0; i < n; i = i + 1)
            i_tst.step(i == n - 1, v[i]);
        r = i_tst.got[63:32] >> (32 - n);
        i_tst.step(1, 1);
        i_tst.step(0, 1);
    end
    endtask
    task ir(input [3:0] op);
    begin
        i_tst.step(1, 1);
        dr({28'h0, op}, 4);
        cap = r[3:0];
    end
    endtask
    task t_idcode;
    begin
        chk("tdoOe_b", 1, tdoOe_b);
        chk("padOut", coreOut, padOut);
        chk("coreIn", padIn, coreIn);
        chk("coreIoIn", coreIoOut, coreIoIn);
        i_tst.step(0, 1);
        dr(0, 32);
        chk("idcode", ID, r);
    end
    endtask
    task t_bypass;
    begin
        ir(`JTB_OP_BYPASS);
        chk("irCapture", `JTB_IR_CAPTURE, cap);
        dr(32'hb5, 9);
        chk("bypass", 32'h16a, r);
    end
    endtask
    task t_extest;
    begin
        padIn = 2'h1;
        ir(`JTB_OP_SAMPLE);
        dr(32'h78, 8);
        chk("sampleIn", padIn, r[1:0]);
        chk("sampleOut", coreOut, r[3:2]);
        chk("sampleNoDrive", coreOut, padOut);
        ir(`JTB_OP_EXTEST);
        clks(2);
        chk("extestOut", 2'h2, padOut);
        chk("extestIo", 2'h3, padIoOut);
        chk("extestIoOe", 2'h1, padIoOe_b);
        testRst_b = 1'b0;
        coreOut = 2'h3;
        clks(2);
        chk("asyncReset", coreOut, padOut);
        testRst_b = 1'b1;
        clks(2);
        i_tst.step(0, 1);
    end
    endtask
    task t_highz;
    begin
        ir(`JTB_OP_HIGHZ);
        clks(2);
        chk("highzOut", 2'h3, padOutOe_b);
        chk("highzIo", 2'h3, padIoOe_b);
        chk("highzIoIn", extIo, coreIoIn);
        dr(32'hb5, 9);
        chk("highzBypass", 32'h16a, r);
        repeat (`JTB_TMS_RESET_CYCLES) i_tst.step(1, 1);
        clks(2);
        chk("tmsReset", 2'h0, padOutOe_b);
        i_tst.step(0, 1);
        dr(0, 32);
        chk("idAfterReset", ID, r);
    end
    endtask
    task t_scan;
    begin
        ir(`JTB_OP_SCAN);
        steps = 0;
        dr(32'h15, 6);
        chk("scanSteps", 6, steps);
        chk("scanOut", 32'h3f, r);
        chk("scanData", 32'h15, scanWord);
    end
    endtask
    task close_out;
    begin
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    end
    endtask
    // Hang guard
    initial
    begin
        #200000;
        failures = failures + 1;
        close_out;
    end
    // Main sequence
    initial
    begin
        failures = 0;
        total_checks = 0;
        steps = 0;
        rst_b = 1'b0;
        testRst_b = 1'b0;
        scanReturn = 1'b1;
        padIn = 2'h2;
        coreOut = 2'h1;
        coreIoOut = 2'h2;
        coreIoOe_b = 2'h0;
        extIo = 2'h3;
        clks(3);
        rst_b = 1'b1;
        clks(2);
        testRst_b = 1'b1;
        clks(4);
        t_idcode;
        t_bypass;
        t_extest;
        t_highz;
        t_scan;
        close_out;
    end
endmodule
